// ===== design/tca_conv_ctrl.sv
// Conversion control, configuration, limits and alert logic of a temperature sensor.
// Assumes the serial engine and the converter run on i_mclk and hand over pulses.
`timescale 1ns/100ps
// Functional notes
// R1: Alert mode: high flag sets on result above high limit, clears on config read.
// R2: Therm mode bit 4: high flag sets above high limit, clears below low limit.
// R3: Alert mode: low flag sets on result below low limit, clears on config read.
// R4: Therm mode holds the low flag at zero.
// R5: Ready flag sets on result update, clears on result or config read.
// R6: Bit 12 shows busy while nonvolatile memory loads or programs.
// R7: Mode 00 continuous, 01 shutdown, 11 one-shot; 10 acts and reads as 00.
// R8: Cycle code sets period; averaging raises the minimum period.
// R9: Averaging code picks 1, 8, 32 or 64 conversions, block averaged.
// R10: Conversions longer than the period run back to back, no standby.
// R11: Polarity bit 3 makes alert pin active high when set.
// R12: Source bit 2 drives alert from ready flag, else from limit flags.
// R13: Writing soft reset bit 1 resets internally for 2 ms; reads zero.
// R14: At reset, storable configuration bits load from nonvolatile memory.
// R15: Mode upper bit never loads from memory; start is shutdown or continuous.
// R16: High limit is 16-bit two's complement, same format as the result.
// R17: High limit reloads from memory after power-up or general-call reset.
// R18: Low limit, same format, reloads from memory after power-up or reset.
// R19: General-call reset returns the registers to power-up values.
// R20: Shutdown converts nothing; one-shot runs one averaged cycle then shuts down.
// R21: Writes to status bits 15:12 and bit 0 have no effect.
module tca_conv_ctrl #(
    parameter int TICK_CYC    = tca_pkg::TICK_CYC_DEF,
    parameter int NV_LOAD_CYC = tca_pkg::NV_LOAD_CYC_DEF
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire tca_pkg::tca_req_t i_req,
    output logic [15:0]            o_rdata,
    output logic                   o_rvalid,
    input  wire logic              i_gcall_rst,
    input  wire tca_pkg::tca_nv_t  i_nv,
    input  wire logic              i_nv_prog,
    output logic                   o_conv_start,
    input  wire logic              i_conv_done,
    input  wire logic [15:0]       i_conv_data,
    output logic                   o_alert
);
    import tca_pkg::*;

    tca_state_t  state_r;
    logic [15:0] cfg_r;
    logic [15:0] thi_r;
    logic [15:0] tlo_r;
    logic [15:0] result_r;
    logic        hi_r;
    logic        lo_r;
    logic        dr_r;
    logic        busy_r;
    logic        hold_r;
    logic [2:0]  srst_cnt_r;
    logic [15:0] load_cnt_r;
    logic        load_r;
    logic [5:0]  cnt_r;
    logic [21:0] acc_r;
    logic [21:0] acc_nxt;
    logic [21:0] avg_full;
    logic        upd_r;
    logic        os_done_r;
    logic        restart_r;
    logic        tick;
    logic        expired;
    logic [15:0] limit;
    logic        wr_cfg;
    logic        wr_thi;
    logic        wr_tlo;
    logic        rd_cfg;
    logic        rd_res;
    logic        srst_req;
    logic        clr_evt;
    logic        os_kick;
    logic        run;
    logic        therm;
    logic        alert_lvl;
    logic [1:0]  mode;
    logic [1:0]  avg_code;
    logic [15:0] cfg_rd;

    assign mode     = cfg_r[MODE_HI:MODE_LO];
    assign avg_code = cfg_r[AVG_HI:AVG_LO];
    assign therm    = cfg_r[BIT_THERM];

    assign wr_cfg = i_req.wr && i_req.addr == OFF_CFG && !hold_r;
    assign wr_thi = i_req.wr && i_req.addr == OFF_THI && !hold_r;
    assign wr_tlo = i_req.wr && i_req.addr == OFF_TLO && !hold_r;
    assign rd_cfg = i_req.rd && i_req.addr == OFF_CFG;
    assign rd_res = i_req.rd && i_req.addr == OFF_RESULT;

    // R13: soft reset request
    assign srst_req = wr_cfg && i_req.wdata[BIT_SRST];
    // R19: general call and soft reset restore power-up values
    assign clr_evt  = srst_req || i_gcall_rst;
    assign os_kick  = wr_cfg && i_req.wdata[MODE_HI:MODE_LO] == MODE_OS;
    // R20: shutdown or reset sequence stops conversions
    assign run      = !hold_r && load_cnt_r == 16'h0 && mode != MODE_SD;

    // R9: block accumulation and divide by shift
    assign acc_nxt  = acc_r + {{6{i_conv_data[15]}}, i_conv_data};
    assign avg_full = $signed(acc_nxt) >>> AVG_SHIFT[avg_code];

    // R8: averaging raises the minimum period
    assign limit = (cycle_ticks(cfg_r[CYC_HI:CYC_LO]) > avg_min_ticks(avg_code)) ?
                   cycle_ticks(cfg_r[CYC_HI:CYC_LO]) : avg_min_ticks(avg_code);

    // R21: status and unused bits come from hardware, not writes
    assign cfg_rd = {hi_r, lo_r && !therm, dr_r, busy_r, cfg_r[11:2], 2'b00};

    // R12: alert source select
    assign alert_lvl = cfg_r[BIT_SRC] ? dr_r : (hi_r || (lo_r && !therm));

    function automatic logic [15:0] fix_cfg(input logic [15:0] w, input logic [15:0] m);
        logic [15:0] c;
        c = w & m;
        // R7: code 10 stored and read back as continuous
        if (c[MODE_HI:MODE_LO] == MODE_ALT) begin
            c[MODE_HI:MODE_LO] = MODE_CC;
        end
        return c;
    endfunction

    tca_period_timer #(
        .TICK_CYC  (TICK_CYC)
    ) u_timer (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_restart (restart_r),
        .i_limit   (limit),
        .o_tick    (tick),
        .o_expired (expired)
    );

    // Reset sequencing: soft reset hold, then nonvolatile load
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            hold_r     <= 1'b0;
            srst_cnt_r <= 3'h0;
            load_cnt_r <= 16'(NV_LOAD_CYC);
            load_r     <= 1'b0;
        end else begin
            load_r <= 1'b0;
            if (i_gcall_rst) begin
                hold_r     <= 1'b0;
                load_cnt_r <= 16'(NV_LOAD_CYC);
            end else if (srst_req) begin
                // R13: internal reset lasts 2 ms
                hold_r     <= 1'b1;
                srst_cnt_r <= 3'(SRST_TICKS);
            end else if (hold_r) begin
                if (tick) begin
                    srst_cnt_r <= srst_cnt_r - 3'h1;
                    if (srst_cnt_r == 3'h1) begin
                        hold_r     <= 1'b0;
                        load_cnt_r <= 16'(NV_LOAD_CYC);
                    end
                end
            end else if (load_cnt_r != 16'h0) begin
                load_cnt_r <= load_cnt_r - 16'h1;
                if (load_cnt_r == 16'h1) begin
                    load_r <= 1'b1;
                end
            end
        end
    end

    // R6: busy while loading or programming
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            busy_r <= 1'b1;
        end else begin
            busy_r <= clr_evt || hold_r || load_cnt_r != 16'h0 || i_nv_prog;
        end
    end

    // Configuration register
    always_ff @(posedge i_mclk) begin
        if (i_rst || clr_evt) begin
            cfg_r <= CFG_RST & CFG_WMASK;
        end else if (load_r) begin
            // R14: storable fields from memory
            // R15: upper mode bit masked off
            cfg_r <= fix_cfg(i_nv.cfg, CFG_NVMASK);
        end else if (wr_cfg) begin
            // R21: only writable bits stored
            cfg_r <= fix_cfg(i_req.wdata, CFG_WMASK);
        end else if (os_done_r && mode == MODE_OS) begin
            // R20: one-shot falls back to shutdown
            cfg_r[MODE_HI:MODE_LO] <= MODE_SD;
        end
    end

    // Limit registers
    always_ff @(posedge i_mclk) begin
        if (i_rst || clr_evt) begin
            thi_r <= THI_RST;
            tlo_r <= TLO_RST;
        end else if (load_r) begin
            // R17: high limit from memory
            thi_r <= i_nv.thi;
            // R18: low limit from memory
            tlo_r <= i_nv.tlo;
        end else begin
            if (wr_thi) begin
                thi_r <= i_req.wdata;
            end
            if (wr_tlo) begin
                tlo_r <= i_req.wdata;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge i_mclk) begin
        if (i_rst || clr_evt) begin
            state_r      <= ST_IDLE;
            cnt_r        <= 6'h0;
            acc_r        <= 22'h0;
            result_r     <= RESULT_RST;
            o_conv_start <= 1'b0;
            upd_r        <= 1'b0;
            os_done_r    <= 1'b0;
            restart_r    <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            upd_r        <= 1'b0;
            os_done_r    <= 1'b0;
            restart_r    <= 1'b0;
            if (!run) begin
                // R20: shutdown aborts any cycle
                state_r <= ST_IDLE;
                cnt_r   <= 6'h0;
                acc_r   <= 22'h0;
            end else if (os_kick || state_r == ST_IDLE) begin
                state_r   <= ST_START;
                cnt_r     <= 6'h0;
                acc_r     <= 22'h0;
                restart_r <= 1'b1;
            end else begin
                unique case (state_r)
                    ST_START: begin
                        o_conv_start <= 1'b1;
                        state_r      <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (i_conv_done) begin
                            // R9: update only after the whole block
                            if (cnt_r == AVG_LAST[avg_code]) begin
                                // R5: result update marks data ready
                                result_r <= avg_full[15:0];
                                upd_r    <= 1'b1;
                                cnt_r    <= 6'h0;
                                acc_r    <= 22'h0;
                                state_r  <= ST_STBY;
                                // R20: single cycle then shutdown
                                os_done_r <= (mode == MODE_OS);
                            end else begin
                                acc_r   <= acc_nxt;
                                cnt_r   <= cnt_r + 6'h1;
                                state_r <= ST_START;
                            end
                        end
                    end
                    ST_STBY: begin
                        // R10: an elapsed period restarts at once
                        if (expired && mode != MODE_OS) begin
                            state_r   <= ST_START;
                            restart_r <= 1'b1;
                        end
                    end
                    ST_IDLE: begin
                        state_r <= ST_START;
                    end
                endcase
            end
        end
    end

    // Status flags; a set in the same cycle as a clear wins
    always_ff @(posedge i_mclk) begin
        if (i_rst || clr_evt) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
            dr_r <= 1'b0;
        end else begin
            // R16: signed compare against the limits
            if (upd_r && $signed(result_r) > $signed(thi_r)) begin
                // R1: set above high limit
                // R2: same set in therm mode
                hi_r <= 1'b1;
            end else if (therm ? (upd_r && $signed(result_r) < $signed(tlo_r)) : rd_cfg) begin
                // R2: therm clears below hysteresis
                // R1: alert clears on read
                hi_r <= 1'b0;
            end
            if (therm) begin
                // R4: low flag held off
                lo_r <= 1'b0;
            end else if (upd_r && $signed(result_r) < $signed(tlo_r)) begin
                // R3: set below low limit
                lo_r <= 1'b1;
            end else if (rd_cfg) begin
                // R3: clear on read
                lo_r <= 1'b0;
            end
            if (upd_r) begin
                dr_r <= 1'b1;
            end else if (rd_cfg || rd_res) begin
                // R5: cleared by either read
                dr_r <= 1'b0;
            end
        end
    end

    // Read port; data shows the value before any read clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata  <= 16'h0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                unique case (i_req.addr)
                    OFF_RESULT: o_rdata <= result_r;
                    OFF_CFG:    o_rdata <= cfg_rd;
                    OFF_THI:    o_rdata <= thi_r;
                    OFF_TLO:    o_rdata <= tlo_r;
                    default:    o_rdata <= 16'h0;
                endcase
            end
        end
    end

    // Alert pin, inactive high after reset since polarity resets low
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_alert <= 1'b1;
        end else begin
            // R11: polarity select
            o_alert <= cfg_r[BIT_POL] ? alert_lvl : !alert_lvl;
        end
    end

endmodule

// ===== design/tca_period_timer.sv
// Half-millisecond tick and cycle-period timer.
// Assumes restart is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps
module tca_period_timer #(
    parameter int TICK_CYC = tca_pkg::TICK_CYC_DEF
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_restart,
    input  wire logic [15:0] i_limit,
    output logic             o_tick,
    output logic             o_expired
);
    import tca_pkg::*;

    logic [31:0] pre_r;
    logic [15:0] ticks_r;

    // Prescaler realigned on restart so a period is never short
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_restart) begin
            pre_r  <= 32'h0;
            o_tick <= 1'b0;
        end else if (pre_r == 32'(TICK_CYC - 1)) begin
            pre_r  <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            pre_r  <= pre_r + 32'h1;
            o_tick <= 1'b0;
        end
    end

    // Saturating tick count since the cycle began
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_restart) begin
            ticks_r <= 16'h0;
        end else if (o_tick && ticks_r != 16'hffff) begin
            ticks_r <= ticks_r + 16'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_restart) begin
            o_expired <= 1'b0;
        end else begin
            o_expired <= (ticks_r >= i_limit);
        end
    end

endmodule

// ===== design/tca_pkg.sv
// Constants, types and lookups shared by the conversion control block.
// Assumes one 50 MHz clock and a serial engine that decodes register accesses.
package tca_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_US       = 500;
    localparam int TICK_CYC_DEF  = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int SRST_US       = 2000;
    // Tick phase is free during soft reset, so one extra tick keeps the least time
    localparam int SRST_TICKS    = SRST_US / TICK_US + 1;
    localparam int NV_LOAD_CYC_DEF = 16;

    // Register offsets
    localparam logic [7:0] OFF_RESULT = 8'h00;
    localparam logic [7:0] OFF_CFG    = 8'h01;
    localparam logic [7:0] OFF_THI    = 8'h02;
    localparam logic [7:0] OFF_TLO    = 8'h03;

    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h8000;
    localparam logic [15:0] CFG_RST    = 16'h0220;
    localparam logic [15:0] THI_RST    = 16'h6000;
    localparam logic [15:0] TLO_RST    = 16'h8000;

    // Configuration field positions
    localparam int BIT_HI_FLAG = 15;
    localparam int BIT_LO_FLAG = 14;
    localparam int BIT_DR_FLAG = 13;
    localparam int BIT_BUSY    = 12;
    localparam int MODE_HI     = 11;
    localparam int MODE_LO     = 10;
    localparam int CYC_HI      = 9;
    localparam int CYC_LO      = 7;
    localparam int AVG_HI      = 6;
    localparam int AVG_LO      = 5;
    localparam int BIT_THERM   = 4;
    localparam int BIT_POL     = 3;
    localparam int BIT_SRC     = 2;
    localparam int BIT_SRST    = 1;

    // Writable bits and bits kept in nonvolatile memory
    localparam logic [15:0] CFG_WMASK  = 16'h0ffc;
    localparam logic [15:0] CFG_NVMASK = 16'h07fc;

    // Conversion mode codes
    localparam logic [1:0] MODE_CC  = 2'h0;
    localparam logic [1:0] MODE_SD  = 2'h1;
    localparam logic [1:0] MODE_ALT = 2'h2;
    localparam logic [1:0] MODE_OS  = 2'h3;

    // Averaging: last index and divide shift per code
    localparam logic [5:0] AVG_LAST  [4] = '{6'h00, 6'h07, 6'h1f, 6'h3f};
    localparam logic [2:0] AVG_SHIFT [4] = '{3'h0, 3'h3, 3'h5, 3'h6};

    // Cycle times and averaging minimum periods, in microseconds
    localparam int CYCLE_US [8] = '{15500, 125000, 250000, 500000,
                                    1000000, 4000000, 8000000, 16000000};
    localparam int AVG_MIN_US [4] = '{0, 125000, 500000, 1000000};

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b10,
        ST_STBY  = 2'b11
    } tca_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } tca_req_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] thi;
        logic [15:0] tlo;
    } tca_nv_t;

    function automatic logic [15:0] cycle_ticks(input logic [2:0] code);
        return 16'(CYCLE_US[code] / TICK_US);
    endfunction

    function automatic logic [15:0] avg_min_ticks(input logic [1:0] code);
        return 16'(AVG_MIN_US[code] / TICK_US);
    endfunction

endpackage

// ===== sim/tca_conv_ctrl_monitor.sv
// Port-level assertions for the conversion control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module tca_conv_ctrl_monitor
    import tca_pkg::*;
#(
    parameter int TICK_CYC    = tca_pkg::TICK_CYC_DEF,
    parameter int NV_LOAD_CYC = tca_pkg::NV_LOAD_CYC_DEF
) (
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire tca_pkg::tca_req_t i_req,
    input wire logic [15:0]       o_rdata,
    input wire logic              o_rvalid,
    input wire logic              i_gcall_rst,
    input wire tca_pkg::tca_nv_t  i_nv,
    input wire logic              i_nv_prog,
    input wire logic              o_conv_start,
    input wire logic              i_conv_done,
    input wire logic [15:0]       i_conv_data,
    input wire logic              o_alert
);
    logic rd_cfg;
    assign rd_cfg = i_req.rd && i_req.addr == OFF_CFG;
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    alert_idle_a: assert property ($fell(i_rst) |-> o_alert)
        else $error("alert pin active after reset");
    cfg_low_bits_a: assert property (rd_cfg |=> o_rdata[1:0] == 2'b00)
        else $error("config bits 1:0 not zero");
    mode_code_a: assert property (rd_cfg |=> o_rdata[11:10] != 2'b10)
        else $error("mode code 10 read back");
    therm_low_a: assert property (rd_cfg |=> !(o_rdata[4] && o_rdata[14]))
        else $error("low flag set in therm mode");
    srst_factory_a: assert property ((i_req.wr && i_req.addr == OFF_CFG
        && i_req.wdata[1]) ##[1:2] rd_cfg |=> o_rdata == (CFG_RST | 16'h1000))
        else $error("soft reset did not restore config");
    gcall_thi_a: assert property (i_gcall_rst
        ##[1:4] (i_req.rd && i_req.addr == OFF_THI) |=> o_rdata == THI_RST)
        else $error("general call did not restore high limit");
    dr_clear_a: assert property ((i_req.rd && i_req.addr == OFF_RESULT) ##[1:2] rd_cfg
        |=> !o_rdata[13])
        else $error("ready flag survived result read");
    hi_clear_a: assert property (rd_cfg ##1 !o_rdata[4] ##1 rd_cfg |=> !o_rdata[15])
        else $error("high flag survived config read");
    start_gap_a: assert property (o_conv_start |=> !o_conv_start [*2])
        else $error("conversion starts too close");

    cover property (rd_cfg ##1 o_rdata[15]);
    cover property (o_conv_start);
    cover property (i_gcall_rst);
endmodule

bind tca_conv_ctrl tca_conv_ctrl_monitor #(
    .TICK_CYC    (TICK_CYC),
    .NV_LOAD_CYC (NV_LOAD_CYC)
) mon (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_gcall_rst(i_gcall_rst), .i_nv(i_nv), .i_nv_prog(i_nv_prog),
    .o_conv_start(o_conv_start), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_alert(o_alert)
);

// ===== sim/tca_conv_ctrl_tb.sv
// Self-checking bench for the conversion control block.
// Assumes the host model drives accesses and a local converter answers starts.
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("[FAIL] %s exp %h got %h", nm, e, g); \
        end \
    end
module tca_conv_ctrl_tb;
    import tca_pkg::*;
    localparam int NCONV [4] = '{1, 8, 32, 64};
    logic        i_mclk, i_rst, i_gcall_rst, i_nv_prog, i_conv_done, use_rnd;
    logic        o_rvalid, o_conv_start, o_alert;
    logic [15:0] i_conv_data, o_rdata, fix, e_w, tv;
    logic [31:0] rs = 32'h072c;
    tca_req_t    i_req;
    tca_nv_t     i_nv;
    int          err_count, n_compared, n_starts, sum, tmo;
    string       n_w;
    logic [15:0] exp_q[$];
    string       nm_q[$];

    tca_conv_ctrl #(.TICK_CYC(4)) uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_gcall_rst(i_gcall_rst), .i_nv(i_nv), .i_nv_prog(i_nv_prog),
        .o_conv_start(o_conv_start), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
        .o_alert(o_alert)
    );
    tca_host_model host (.i_mclk(i_mclk), .o_req(i_req));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        host.acc(1'b0, a, 16'h0000);
    endtask

    // One-shot cycle, then a long quiet stretch to catch extra starts
    task automatic shot(input logic [15:0] c, input logic [15:0] f, input int n);
        fix = f;
        n_starts = 0;
        sum = 0;
        wr(OFF_CFG, c | 16'h0c00);
        for (tmo = 0; tmo < 3000 && n_starts < n; tmo++) @(posedge i_mclk);
        repeat (150) @(posedge i_mclk);
        #1 `CHK("start count", n, n_starts)
        if (tmo == 3000) tally_and_finish();
    endtask

    task automatic chk_alert(input logic e);
        repeat (3) @(posedge i_mclk);
        #1 `CHK("alert pin", e, o_alert)
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // Converter answers two cycles after a start; bus inverts when idle
    initial begin
        i_conv_done = 1'b0;
        i_conv_data = 16'h0000;
        forever begin
            @(posedge i_mclk);
            if (o_conv_start === 1'b1) begin
                rs = xs(rs);
                repeat (2) @(posedge i_mclk);
                #1 i_conv_data = use_rnd ? {8'h00, rs[7:0]} : fix;
                i_conv_done = 1'b1;
                n_starts++;
                sum += int'(signed'(i_conv_data));
                @(posedge i_mclk);
                #1 i_conv_done = 1'b0;
                i_conv_data = ~i_conv_data;
            end
        end
    end

    always @(negedge i_mclk) begin
        if (o_rvalid === 1'b1) begin
            if (exp_q.size() > 0) begin
                e_w = exp_q.pop_front();
                n_w = nm_q.pop_front();
                `CHK(n_w, e_w, o_rdata)
            end else begin
                `CHK("unrequested read", 1'b0, o_rvalid)
            end
        end
    end

    initial begin
        i_rst = 1'b1;
        i_gcall_rst = 1'b0;
        i_nv_prog = 1'b0;
        use_rnd = 1'b0;
        fix = 16'h0000;
        // Stored image sets mode upper bit, which must not load
        i_nv = '{cfg: 16'h0e20, thi: 16'h1000, tlo: 16'hf000};
        repeat (6) @(posedge i_mclk);
        #1 i_rst = 1'b0;
        rd(OFF_CFG, 16'h1220, "cfg factory busy");
        repeat (30) @(posedge i_mclk);
        rd(OFF_CFG, 16'h0620, "cfg loaded");
        rd(OFF_THI, 16'h1000, "high limit loaded");
        rd(OFF_TLO, 16'hf000, "low limit loaded");
        rd(OFF_RESULT, RESULT_RST, "result at reset");
        rd(8'h05, 16'h0000, "unmapped read");
        @(posedge i_mclk);
        #1 i_nv_prog = 1'b1;
        rd(OFF_CFG, 16'h1620, "busy while programming");
        @(posedge i_mclk);
        #1 i_nv_prog = 1'b0;
        rs = xs(rs);
        tv = rs[15:0];
        wr(OFF_THI, tv);
        rd(OFF_THI, tv, "high limit rw");
        wr(OFF_CFG, 16'hf405);
        rd(OFF_CFG, 16'h0404, "status bits kept");
        wr(OFF_THI, 16'h0100);
        wr(OFF_TLO, 16'hff00);
        shot(16'h0008, 16'h0200, 1);
        chk_alert(1'b1);
        rd(OFF_CFG, 16'ha408, "high flag set");
        rd(OFF_CFG, 16'h0408, "high flag cleared");
        rd(OFF_RESULT, 16'h0200, "one shot result");
        shot(16'h0000, 16'hfe00, 1);
        chk_alert(1'b0);
        rd(OFF_CFG, 16'h6400, "low flag set");
        rd(OFF_CFG, 16'h0400, "low flag cleared");
        use_rnd = 1'b1;
        for (int a = 0; a < 4; a++) begin
            shot(16'h0004 | 16'(a << 5), 16'h0000, NCONV[a]);
            chk_alert(1'b0);
            rd(OFF_RESULT, 16'(sum >>> AVG_SHIFT[a]), "block average");
            rd(OFF_CFG, 16'h0404 | 16'(a << 5), "ready cleared");
        end
        use_rnd = 1'b0;
        wr(OFF_TLO, 16'h0050);
        shot(16'h0010, 16'h0200, 1);
        rd(OFF_CFG, 16'ha410, "therm high set");
        rd(OFF_CFG, 16'h8410, "therm high kept");
        shot(16'h0010, 16'h0010, 1);
        rd(OFF_CFG, 16'h2410, "therm high released");
        n_starts = 0;
        wr(OFF_CFG, 16'h0800);
        rd(OFF_CFG, 16'h0000, "mode code 10");
        repeat (300) @(posedge i_mclk);
        #1 `CHK("continuous starts", 3, n_starts)
        wr(OFF_CFG, 16'h0400);
        repeat (10) @(posedge i_mclk);
        n_starts = 0;
        repeat (200) @(posedge i_mclk);
        #1 `CHK("shutdown starts", 0, n_starts)
        wr(OFF_CFG, 16'h0002);
        rd(OFF_CFG, 16'h1220, "soft reset factory");
        wr(OFF_THI, 16'h1234);
        rd(OFF_THI, THI_RST, "write ignored in hold");
        repeat (80) @(posedge i_mclk);
        rd(OFF_CFG, 16'h0620, "cfg reloaded");
        wr(OFF_THI, 16'h1234);
        @(posedge i_mclk);
        #1 i_gcall_rst = 1'b1;
        @(posedge i_mclk);
        #1 i_gcall_rst = 1'b0;
        rd(OFF_THI, THI_RST, "general call factory");
        repeat (40) @(posedge i_mclk);
        rd(OFF_THI, 16'h1000, "high limit reloaded");
        rd(OFF_TLO, 16'hf000, "low limit reloaded");
        repeat (4) @(posedge i_mclk);
        #1 `CHK("reads answered", 0, exp_q.size())
        tally_and_finish();
    end
endmodule

// ===== sim/tca_host_model.sv
// Host controller model issuing register accesses.
// Assumes an access is taken on the next rising edge of i_mclk.
`timescale 1ns/100ps
module tca_host_model (
    input  wire logic          i_mclk,
    output tca_pkg::tca_req_t  o_req
);
    import tca_pkg::*;
    initial o_req = '0;
    // Host side accesses
    // Idle fields show the inverse, never a stale copy
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        #1 o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_mclk);
        #1 o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule
